/* core/adc_output_format_power_ctrl.sv */
// output formatting, clock stabiliser model and power states of a 12-bit
// pipelined converter; assumes the quantiser result arrives on core_clk and
// the conversion clock, power, enable and strap pins arrive asynchronously
//
// Function
// - sample on conversion clock rising edge only
// - stabiliser keeps internal duty at one half
// - relock needs hundred edges after clock stop
// - strap ground or one-third: offset binary
// - strap two-thirds or full: two's complement
// - stabiliser on only for middle strap levels
// - midscale 800, twos complement flips top bit
// - overrange flag holds full-scale code
// - enable-bar high makes the data outputs high-z
// - power-down low: convert every clock the output buffer can take
// - power-down and enable-bar high: sleep
// - sleep exit waits a millisecond before valid
// - power-down with enable low: nap (sleep if in or leaving sleep), 100 edges
// - sleep and nap force outputs high-z
`timescale 1ns/1ns
`default_nettype none
module adc_output_format_power_ctrl #(
  parameter int SLEEP_RECOVERY_CYCLES = adc_fmt_pkg::SLEEP_RECOVERY_CYCLES
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         clk_en,
  // board pins
  input  wire logic                         conv_clk_pin,
  input  wire logic                         power_down_request,
  input  wire logic                         output_enable_b,
  input  wire logic [1:0]                   format_strap,
  // quantiser result
  input  wire adc_fmt_pkg::quant_type       quant,
  // parallel output pins
  output var  adc_fmt_pkg::sample_type      pin_data,
  output logic                              pin_data_oe,
  // capture handshake
  output logic                              sample_valid,
  input  wire logic                         sample_ready,
  // status
  output logic                              stabilizer_on,
  output logic                              stabilizer_locked,
  output logic                              duty_in_range,
  output logic                              twos_complement,
  output logic                              data_good,
  output var  adc_fmt_pkg::power_state_type power_state
);

  localparam int LAT = adc_fmt_pkg::PIPE_LATENCY;
  localparam int SW  = $bits(adc_fmt_pkg::sample_type);

  adc_fmt_pkg::core_state_type s_ff;
  adc_fmt_pkg::core_state_type nxt_s;
  adc_fmt_pkg::pin_type        pins_raw;
  adc_fmt_pkg::pin_type        pins_s;
  logic                        conv_rise;
  logic                        converting;
  logic                        timing_ok;
  logic                        shift;
  logic                        push;
  logic                        buf_in_ready;
  logic [SW-1:0]               buf_q;
  logic [SW-1:0]               buf_d;
  logic [adc_fmt_pkg::SAMPLE_W-1:0] fmt_code;
  adc_fmt_pkg::pct_type        hi_pct;
  adc_fmt_pkg::pct_type        per_lo;
  adc_fmt_pkg::pct_type        per_hi;
  logic [adc_fmt_pkg::CNT_W-1:0] period;

  ////////////////////////////////////////////////////////////////////////////
  // pins cross into the core clock
  assign pins_raw = '{conv_clk:           conv_clk_pin,
                      power_down_request: power_down_request,
                      output_enable_b:    output_enable_b,
                      format_strap:       format_strap};

  pin_sync2 #(
    .W ($bits(adc_fmt_pkg::pin_type))
  ) u_pin_sync (
    .clk    (core_clk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .d      (pins_raw),
    .q      (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_s      = s_ff;
    conv_rise  = pins_s.conv_clk && !s_ff.conv_prev;
    converting = (s_ff.pwr != adc_fmt_pkg::PWR_NAP) &&
                 (s_ff.pwr != adc_fmt_pkg::PWR_SLEEP);
    timing_ok  = !s_ff.dcs_on || s_ff.locked;
    period     = s_ff.cnt + 16'h0001;
    hi_pct     = adc_fmt_pkg::pct_type'(s_ff.high_cnt) *
                 adc_fmt_pkg::pct_type'(adc_fmt_pkg::PCT_FULL);
    per_lo     = adc_fmt_pkg::pct_type'(period) * (s_ff.dcs_on ?
                 adc_fmt_pkg::pct_type'(adc_fmt_pkg::DUTY_ON_MIN_PCT) :
                 adc_fmt_pkg::pct_type'(adc_fmt_pkg::DUTY_OFF_MIN_PCT));
    per_hi     = adc_fmt_pkg::pct_type'(period) * (s_ff.dcs_on ?
                 adc_fmt_pkg::pct_type'(adc_fmt_pkg::DUTY_ON_MAX_PCT) :
                 adc_fmt_pkg::pct_type'(adc_fmt_pkg::DUTY_OFF_MAX_PCT));
    shift      = conv_rise && converting && buf_in_ready;
    push       = shift && s_ff.pipe[LAT-1].good;

    // strap decode: upper bit picks the coding, middle levels the loop
    nxt_s.twos   = pins_s.format_strap[1];
    nxt_s.dcs_on = ^pins_s.format_strap;

    // clock period, high time and duty window
    nxt_s.conv_prev = pins_s.conv_clk;
    if (conv_rise) begin
      nxt_s.cnt       = '0;
      nxt_s.high_cnt  = 16'h0001;  // the rising cycle itself is high
      nxt_s.period_ff = period;
      nxt_s.int_clk   = 1'b1;
      nxt_s.stopped   = 1'b0;
      nxt_s.duty_ok   = (hi_pct >= per_lo) && (hi_pct <= per_hi);
    end else begin
      if (s_ff.cnt < 16'(adc_fmt_pkg::STOP_GAP_CYCLES)) begin
        nxt_s.cnt = s_ff.cnt + 16'h0001;
      end else begin
        nxt_s.stopped = 1'b1;
      end
      if (pins_s.conv_clk && (s_ff.high_cnt != 16'hFFFF)) begin
        nxt_s.high_cnt = s_ff.high_cnt + 16'h0001;
      end
      // the loop makes its own falling edge at half the period
      if (s_ff.dcs_on) begin
        if (period >= (s_ff.period_ff >> 1)) begin
          nxt_s.int_clk = 1'b0;
        end
      end else begin
        nxt_s.int_clk = pins_s.conv_clk;
      end
    end

    // loop lock: counts edges, lost on a stop, a mode change or power-down
    if (s_ff.stopped || !converting || (nxt_s.dcs_on != s_ff.dcs_on)) begin
      nxt_s.lock_cnt = '0;
      nxt_s.locked   = 1'b0;
    end else if (conv_rise && s_ff.dcs_on && !s_ff.locked) begin
      if (s_ff.lock_cnt == 7'(adc_fmt_pkg::RELOCK_EDGES - 1)) begin
        nxt_s.locked = 1'b1;
      end else begin
        nxt_s.lock_cnt = s_ff.lock_cnt + 7'h01;
      end
    end

    // power states follow the two pins
    case (s_ff.pwr)
      adc_fmt_pkg::PWR_ACTIVE: begin
        if (pins_s.power_down_request && pins_s.output_enable_b) begin
          nxt_s.pwr = adc_fmt_pkg::PWR_SLEEP;
        end else if (pins_s.power_down_request) begin
          nxt_s.pwr = adc_fmt_pkg::PWR_NAP;
        end
      end
      adc_fmt_pkg::PWR_NAP: begin
        if (pins_s.power_down_request && pins_s.output_enable_b) begin
          nxt_s.pwr = adc_fmt_pkg::PWR_SLEEP;
        end else if (!pins_s.power_down_request) begin
          nxt_s.pwr      = adc_fmt_pkg::PWR_NAP_WAKE;
          nxt_s.wake_cnt = '0;
        end
      end
      adc_fmt_pkg::PWR_SLEEP: begin
        // the reference is down, so any exit pays the long recharge
        if (!pins_s.power_down_request) begin
          nxt_s.pwr      = adc_fmt_pkg::PWR_SLEEP_WAKE;
          nxt_s.wake_cnt = '0;
        end
      end
      adc_fmt_pkg::PWR_NAP_WAKE: begin
        if (pins_s.power_down_request) begin
          nxt_s.pwr = pins_s.output_enable_b ? adc_fmt_pkg::PWR_SLEEP :
                      adc_fmt_pkg::PWR_NAP;
        end else if (conv_rise) begin
          if (s_ff.wake_cnt ==
              20'(adc_fmt_pkg::NAP_RECOVERY_EDGES - 1)) begin
            nxt_s.pwr = adc_fmt_pkg::PWR_ACTIVE;
          end else begin
            nxt_s.wake_cnt = s_ff.wake_cnt + 20'h00001;
          end
        end
      end
      adc_fmt_pkg::PWR_SLEEP_WAKE: begin
        if (pins_s.power_down_request) begin
          nxt_s.pwr = adc_fmt_pkg::PWR_SLEEP;
        end else if (s_ff.wake_cnt == 20'(SLEEP_RECOVERY_CYCLES - 1)) begin
          nxt_s.pwr = adc_fmt_pkg::PWR_ACTIVE;
        end else begin
          nxt_s.wake_cnt = s_ff.wake_cnt + 20'h00001;
        end
      end
      default: begin
        nxt_s.pwr = adc_fmt_pkg::PWR_SLEEP_WAKE;
      end
    endcase

    // drivers off when enable-bar is high or the part is powered down
    nxt_s.out_en = !pins_s.output_enable_b &&
                   (nxt_s.pwr != adc_fmt_pkg::PWR_NAP) &&
                   (nxt_s.pwr != adc_fmt_pkg::PWR_SLEEP);

    // coding: clamp on overrange, then flip the top bit for twos complement
    if (quant.over) begin
      fmt_code = adc_fmt_pkg::CODE_POS_FS;
    end else if (quant.under) begin
      fmt_code = adc_fmt_pkg::CODE_NEG_FS;
    end else begin
      fmt_code = quant.code;
    end
    fmt_code[adc_fmt_pkg::SIGN_BIT] = fmt_code[adc_fmt_pkg::SIGN_BIT] ^
                                      s_ff.twos;

    // data and flag move as one word; a refused edge takes no sample
    if (shift) begin
      for (int i = LAT - 1; i > 0; i--) begin
        nxt_s.pipe[i] = s_ff.pipe[i-1];
      end
      nxt_s.pipe[0].good                 = (s_ff.pwr ==
                                            adc_fmt_pkg::PWR_ACTIVE) &&
                                           timing_ok;
      nxt_s.pipe[0].s.sample_bits        = fmt_code;
      nxt_s.pipe[0].s.overrange_flag     = quant.over || quant.under;
    end
    // samples caught before a power-down never reach the pins
    if (!converting) begin
      for (int i = 0; i < LAT; i++) begin
        nxt_s.pipe[i].good = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= adc_fmt_pkg::CORE_RESET;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer: a stalled receiver holds the word, then the pipeline
  assign buf_d = s_ff.pipe[LAT-1].s;

  skid_buffer2 #(
    .W (SW)
  ) u_out_buf (
    .clk       (core_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (buf_d),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (buf_q)
  );

  assign pin_data          = adc_fmt_pkg::sample_type'(buf_q);
  assign pin_data_oe       = s_ff.out_en;
  assign stabilizer_on     = s_ff.dcs_on;
  assign stabilizer_locked = s_ff.locked;
  assign duty_in_range     = s_ff.duty_ok;
  assign twos_complement   = s_ff.twos;
  assign data_good         = (s_ff.pwr == adc_fmt_pkg::PWR_ACTIVE) &&
                             (!s_ff.dcs_on || s_ff.locked);
  assign power_state       = s_ff.pwr;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [adc_fmt_pkg::CNT_W-1:0] int_hi_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_hi_ff <= '0;
    end else if (clk_en) begin
      int_hi_ff <= s_ff.int_clk ? int_hi_ff + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b || !clk_en);

  sequence sleep_req;
    pins_s.power_down_request && pins_s.output_enable_b;
  endsequence
  sequence nap_req;
    pins_s.power_down_request && !pins_s.output_enable_b;
  endsequence
  sequence active_now;
    s_ff.pwr == adc_fmt_pkg::PWR_ACTIVE;
  endsequence

  a_sleep_entry: assert property (
    active_now ##0 sleep_req |=> s_ff.pwr == adc_fmt_pkg::PWR_SLEEP)
    else $error("sleep not entered");
  a_nap_entry: assert property (
    active_now ##0 nap_req |=> s_ff.pwr == adc_fmt_pkg::PWR_NAP)
    else $error("nap not entered");
  a_power_hiz: assert property (
    (s_ff.pwr == adc_fmt_pkg::PWR_SLEEP || s_ff.pwr == adc_fmt_pkg::PWR_NAP)
    |-> !pin_data_oe)
    else $error("outputs driven while powered down");
  a_enable_hiz: assert property (
    pins_s.output_enable_b |=> !pin_data_oe)
    else $error("outputs driven with enable-bar high");
  a_strap_decode: assert property (
    1'b1 |=> stabilizer_on == ^$past(pins_s.format_strap) &&
             twos_complement == $past(pins_s.format_strap[1]))
    else $error("strap decode wrong");
  a_relock_count: assert property (
    $rose(stabilizer_locked) |->
      $past(s_ff.lock_cnt) == adc_fmt_pkg::RELOCK_EDGES - 1)
    else $error("lock before hundred edges");
  a_half_duty: assert property (
    $fell(s_ff.int_clk) && $past(s_ff.dcs_on) && s_ff.period_ff >= 16'h0004
    |-> int_hi_ff == (s_ff.period_ff >> 1))
    else $error("internal high time not half period");
  a_over_code: assert property (
    shift && quant.over |=> s_ff.pipe[0].s.overrange_flag &&
      s_ff.pipe[0].s.sample_bits[10:0] == 11'h7FF)
    else $error("overrange code not full scale");
  a_coding_sign: assert property (
    shift && !quant.over && !quant.under |=>
      s_ff.pipe[0].s.sample_bits ==
      {$past(quant.code[11]) ^ $past(s_ff.twos), $past(quant.code[10:0])})
    else $error("output coding wrong");
  a_sample_edge: assert property (
    !conv_rise && converting |=> $stable(s_ff.pipe))
    else $error("pipeline moved without a rising edge");
  a_pipe_latency: assert property (
    shift |=> s_ff.pipe[LAT-1] == $past(s_ff.pipe[LAT-2]))
    else $error("pipeline stage skipped");
  a_active_convert: assert property (
    active_now ##0 conv_rise && buf_in_ready |=>
      s_ff.pipe[1] == $past(s_ff.pipe[0]))
    else $error("edge not converted");
  a_nap_recover: assert property (
    s_ff.pwr == adc_fmt_pkg::PWR_ACTIVE &&
    $past(s_ff.pwr) == adc_fmt_pkg::PWR_NAP_WAKE |->
      $past(s_ff.wake_cnt) == adc_fmt_pkg::NAP_RECOVERY_EDGES - 1)
    else $error("nap recovery too short");
  a_sleep_recover: assert property (
    s_ff.pwr == adc_fmt_pkg::PWR_ACTIVE &&
    $past(s_ff.pwr) == adc_fmt_pkg::PWR_SLEEP_WAKE |->
      $past(s_ff.wake_cnt) == SLEEP_RECOVERY_CYCLES - 1)
    else $error("sleep recovery too short");

endmodule : adc_output_format_power_ctrl
`default_nettype wire

/* core/pin_sync2.sv */
// two-stage synchroniser for a group of board pins
// assumes the pins are quasi-static or slow next to the core clock
`timescale 1ns/1ns
`default_nettype none
module pin_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // pins in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_type;

  sync_state_type s_ff;
  sync_state_type nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // the first stage feeds only the second
  always_comb begin
    nxt_s        = s_ff;
    nxt_s.meta   = d;
    nxt_s.stable = s_ff.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.stable;

endmodule : pin_sync2
`default_nettype wire

/* core/skid_buffer2.sv */
// two-entry buffer with valid and ready on both sides
// assumes both sides run on the same clock; output data comes from a flop
`timescale 1ns/1ns
`default_nettype none
module skid_buffer2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0]   cnt;
  } buf_state_type;

  buf_state_type s_ff;
  buf_state_type nxt_s;
  logic          push;
  logic          pop;

  ////////////////////////////////////////////////////////////////////////////
  // full refuses the source; it must hold its word
  always_comb begin
    nxt_s = s_ff;
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    case (s_ff.cnt)
      2'h0: begin
        if (push) begin
          nxt_s.head = in_data;
          nxt_s.cnt  = 2'h1;
        end
      end
      2'h1: begin
        if (push && pop) begin
          nxt_s.head = in_data;
        end else if (push) begin
          nxt_s.tail = in_data;
          nxt_s.cnt  = 2'h2;
        end else if (pop) begin
          nxt_s.cnt  = 2'h0;
        end
      end
      default: begin
        if (pop) begin
          nxt_s.head = s_ff.tail;
          nxt_s.cnt  = 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready  = (s_ff.cnt != 2'h2);
  assign out_valid = (s_ff.cnt != 2'h0);
  assign out_data  = s_ff.head;

endmodule : skid_buffer2
`default_nettype wire

/* include/adc_fmt_pkg.sv */
// types and constants for the converter output formatting and power control
// assumes a single 100 MHz core clock shared by every module that imports it
package adc_fmt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and structure
  localparam int SAMPLE_W     = 12;
  localparam int SIGN_BIT     = 11;
  localparam int CNT_W        = 16;
  localparam int LOCK_W       = 7;
  localparam int WAKE_W       = 20;
  localparam int PCT_W        = CNT_W + 8;
  localparam int PIPE_LATENCY = 5;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS         = 10;
  localparam int STOP_GAP_NS           = 1000;
  localparam int STOP_GAP_CYCLES       = STOP_GAP_NS / CLK_PERIOD_NS;
  localparam int SLEEP_RECOVERY_NS     = 1000000;
  localparam int SLEEP_RECOVERY_CYCLES = SLEEP_RECOVERY_NS / CLK_PERIOD_NS;
  localparam int RELOCK_EDGES          = 100;
  localparam int NAP_RECOVERY_EDGES    = 100;

  ////////////////////////////////////////////////////////////////////////////
  // duty cycle windows, in percent
  localparam int DUTY_ON_MIN_PCT  = 40;
  localparam int DUTY_ON_MAX_PCT  = 60;
  localparam int DUTY_OFF_MIN_PCT = 45;
  localparam int DUTY_OFF_MAX_PCT = 55;
  localparam int PCT_FULL         = 100;

  ////////////////////////////////////////////////////////////////////////////
  // output codes, offset binary
  localparam logic [SAMPLE_W-1:0] CODE_POS_FS = 12'hFFF;
  localparam logic [SAMPLE_W-1:0] CODE_NEG_FS = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [PCT_W-1:0] pct_type;

  typedef struct packed {
    logic       conv_clk;
    logic       power_down_request;
    logic       output_enable_b;
    logic [1:0] format_strap;
  } pin_type;

  typedef struct packed {
    logic                over;
    logic                under;
    logic [SAMPLE_W-1:0] code;
  } quant_type;

  typedef struct packed {
    logic                overrange_flag;
    logic [SAMPLE_W-1:0] sample_bits;
  } sample_type;

  typedef struct packed {
    logic       good;
    sample_type s;
  } stage_type;

  typedef enum logic [2:0] {
    PWR_ACTIVE     = 3'h0,
    PWR_NAP        = 3'h1,
    PWR_SLEEP      = 3'h2,
    PWR_NAP_WAKE   = 3'h3,
    PWR_SLEEP_WAKE = 3'h4
  } power_state_type;

  typedef struct packed {
    logic                               conv_prev;
    logic [CNT_W-1:0]                   cnt;
    logic [CNT_W-1:0]                   high_cnt;
    logic [CNT_W-1:0]                   period_ff;
    logic                               int_clk;
    logic                               stopped;
    logic [LOCK_W-1:0]                  lock_cnt;
    logic                               locked;
    logic                               dcs_on;
    logic                               twos;
    logic                               duty_ok;
    power_state_type                    pwr;
    logic [WAKE_W-1:0]                  wake_cnt;
    logic                               out_en;
    stage_type [PIPE_LATENCY-1:0]       pipe;
  } core_state_type;

  localparam core_state_type CORE_RESET = '0;

endpackage : adc_fmt_pkg

/* verification/capture_model.sv */
// capture side model: takes words off the output pins
// assumes the converter block shares the same core clock
`timescale 1ns/1ns
`default_nettype none
module capture_model (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // word stream
  input  wire logic                    sample_valid,
  input  wire adc_fmt_pkg::sample_type pin_data,
  output logic                         sample_ready,
  // control and result
  input  wire logic                    stall,
  output var  adc_fmt_pkg::sample_type last_word
);
  // words are only taken while valid, so recovery junk never lands
  assign sample_ready = !stall;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) last_word <= '0;
    else if (sample_valid && sample_ready) last_word <= pin_data;
  end
endmodule : capture_model
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the converter output and power block
// assumes a 100 MHz core clock and a conversion clock of 8 core cycles
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 0, rst_b = 0, conv = 0, pd = 0, oe_b = 0, stall = 0;
  logic [1:0] strap = 0;
  adc_fmt_pkg::quant_type quant = '0;
  adc_fmt_pkg::sample_type pin_data, last_word;
  adc_fmt_pkg::power_state_type pst;
  logic oe, valid, ready, st_on, st_lock, duty_ok, twos, good;
  int n_errors = 0, comparisons = 0, cyc = 0;
  //////////////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    conv <= (cyc % 8) < 4;
  end
  adc_output_format_power_ctrl #(.SLEEP_RECOVERY_CYCLES(20)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
    .conv_clk_pin(conv), .power_down_request(pd),
    .output_enable_b(oe_b), .format_strap(strap), .quant(quant),
    .pin_data(pin_data), .pin_data_oe(oe), .sample_valid(valid),
    .sample_ready(ready), .stabilizer_on(st_on),
    .stabilizer_locked(st_lock), .duty_in_range(duty_ok),
    .twos_complement(twos), .data_good(good), .power_state(pst));
  capture_model partner (.core_clk(core_clk), .rst_b(rst_b),
    .sample_valid(valid), .pin_data(pin_data), .sample_ready(ready),
    .stall(stall), .last_word(last_word));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic w(int n);
    repeat (n) @(posedge core_clk);
  endtask : w
  task automatic complete_run;
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////
  task automatic t_strap;
    for (int s = 0; s < 4; s++) begin
      strap <= 2'(s);
      w(6);
      check("stab", 16'(st_on), 16'(s == 1 || s == 2));
      check("twos", 16'(twos), 16'(s >= 2));
    end
  endtask : t_strap
  // each row: strap, over, under, code, expected word
  task automatic t_data;
    logic [1:0] s [6] = '{0, 3, 3, 0, 3, 1};
    logic [1:0] ou [6] = '{0, 0, 0, 2, 1, 0};
    logic [11:0] c [6] = '{12'h800, 12'h800, 12'h123, 12'h5A5, 12'h5A5,
                          12'h7FF};
    logic [15:0] e [6] = '{16'h0800, 16'h0000, 16'h0923, 16'h1FFF,
                          16'h1800, 16'h07FF};
    for (int i = 0; i < 6; i++) begin
      strap <= s[i];
      quant <= {ou[i], c[i]};
      w(1000);
      check("word", 16'(last_word), e[i]);
      check("good", 16'(good), 16'h0001);
    end
    check("locked", 16'(st_lock), 16'h0001);
    check("duty", 16'(duty_ok), 16'h0001);
  endtask : t_data
  task automatic t_stall;
    strap <= 2'h0;
    quant <= '{1'b0, 1'b0, 12'h555};
    w(200);
    stall <= 1'b1;
    w(200);
    quant <= '{1'b0, 1'b0, 12'h0AA};
    w(200);
    check("held", 16'({valid, pin_data}), 16'h2555);
    stall <= 1'b0;
    w(300);
    check("after", 16'(last_word), 16'h00AA);
  endtask : t_stall
  task automatic t_power;
    oe_b <= 1'b1;
    w(6);
    check("oe", 16'(oe), 16'h0000);
    oe_b <= 1'b0;
    pd <= 1'b1;
    w(6);
    check("nap", 16'({oe, 5'(pst)}), 16'h0001);
    pd <= 1'b0;
    w(700);
    check("napwake", 16'(pst), 16'h0003);
    w(130);
    check("active", 16'({oe, 5'(pst)}), 16'h0020);
    oe_b <= 1'b1;
    pd <= 1'b1;
    w(6);
    check("sleep", 16'({oe, 5'(pst)}), 16'h0002);
    pd <= 1'b0;
    oe_b <= 1'b0;
    w(12);
    check("sleepwake", 16'({good, 5'(pst)}), 16'h0004);
    w(20);
    check("awake", 16'({good, 5'(pst)}), 16'h0020);
  endtask : t_power
  //////////////////////////////////////////////////////////////////////////
  initial begin
    w(12);
    rst_b <= 1'b1;
    w(10);
    t_strap();
    t_data();
    t_stall();
    t_power();
    complete_run();
  end
  initial begin
    #500000;
    n_errors++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
